// File: verilog/chan_cfg_regs.sv
/*
  Per-channel configuration register bank of a downconverter channel.
  Assumes an APB master, channel-level inputs synchronous to I_SYS_CLK.
*/
`timescale 1ns/1ns
`default_nettype none
module chan_cfg_regs
  import chan_cfg_pkg::*;
#(
  parameter int CHAN_ID = 0
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Channel status
  input wire logic I_LEVEL_IND,
  input wire logic I_FILT_START,
  input wire logic I_OUT_SAMPLE,
  input wire logic [SIG_W-1:0] I_SIG_I,
  input wire logic [SIG_W-1:0] I_SIG_Q,
  // Configuration outputs
  output osc_cfg_t O_OSC_CFG,
  output cf_cfg_t O_CF_CFG,
  output filt_cfg_t O_FILT_CFG,
  output logic O_FIRST_PHASE,
  output logic [7:0] O_COEF_PTR,
  output logic O_COEFFICIENT_MEMORY_WE,
  output logic [7:0] O_COEFFICIENT_MEMORY_ADDR,
  output logic [19:0] O_COEFFICIENT_MEMORY_WDATA
);

  logic [OSC_W-1:0] osc_q;
  logic [RS_DEC_W-1:0] rs_dec_q;
  logic [RS_INT_W-1:0] rs_int_q;
  logic [RS_SCL_W-1:0] rs_scl_q;
  logic [7:0] c5_dec_q;
  logic [C5_SCL_W-1:0] c5_scl_q;
  logic [7:0] cf_dec_q;
  logic [7:0] cf_phase_q;
  logic [7:0] cf_taps_q;
  logic [7:0] cf_off_shadow_q;
  logic [7:0] cf_off_work_q;
  logic [CF_CTRL_W-1:0] cf_ctrl_q;
  logic [7:0] phase_work_q;
  logic [31:0] rdata_d;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic wr_osc;
  logic wr_rs_dec;
  logic wr_rs_int;
  logic wr_rs_scl;
  logic wr_c5_dec;
  logic wr_c5_scl;
  logic wr_cf_dec;
  logic wr_cf_phase;
  logic wr_cf_taps;
  logic wr_cf_off;
  logic wr_cf_ctrl;

  assign idx = I_PADDR[ADDR_W-1:2];
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_en = I_PSEL & ~I_PENABLE & ~I_PWRITE;

  // Write strobes; reserved and unused indices raise none
  always_comb begin
    wr_osc = 1'b0;
    wr_rs_dec = 1'b0;
    wr_rs_int = 1'b0;
    wr_rs_scl = 1'b0;
    wr_c5_dec = 1'b0;
    wr_c5_scl = 1'b0;
    wr_cf_dec = 1'b0;
    wr_cf_phase = 1'b0;
    wr_cf_taps = 1'b0;
    wr_cf_off = 1'b0;
    wr_cf_ctrl = 1'b0;
    if (wr_en) begin
      case (idx)
        IDX_OSC_CTRL: wr_osc = 1'b1;
        IDX_RS_DEC: wr_rs_dec = 1'b1;
        IDX_RS_INTERP: wr_rs_int = 1'b1;
        IDX_RS_SCALE: wr_rs_scl = 1'b1;
        IDX_C5_DEC: wr_c5_dec = 1'b1;
        IDX_C5_SCALE: wr_c5_scl = 1'b1;
        IDX_CF_DEC: wr_cf_dec = 1'b1;
        IDX_CF_PHASE: wr_cf_phase = 1'b1;
        IDX_CF_TAPS: wr_cf_taps = 1'b1;
        IDX_CF_OFFSET: wr_cf_off = 1'b1;
        IDX_CF_CTRL: wr_cf_ctrl = 1'b1;
        default: ;
      endcase
    end
  end

  // Oscillator control
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      osc_q <= RST_ZERO[OSC_W-1:0];
    end else if (wr_osc) begin
      osc_q <= I_PWDATA[OSC_W-1:0] & OSC_WMASK;
    end
  end

  // Resample decimation
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      rs_dec_q <= RST_ZERO[RS_DEC_W-1:0];
    end else if (wr_rs_dec) begin
      rs_dec_q <= I_PWDATA[RS_DEC_W-1:0];
    end
  end

  // Resample interpolation
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      rs_int_q <= RST_ZERO[RS_INT_W-1:0];
    end else if (wr_rs_int) begin
      rs_int_q <= I_PWDATA[RS_INT_W-1:0];
    end
  end

  // Resample scale pair
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      rs_scl_q <= RST_ZERO[RS_SCL_W-1:0];
    end else if (wr_rs_scl) begin
      rs_scl_q <= I_PWDATA[RS_SCL_W-1:0] & RS_SCL_WMASK;
    end
  end

  // Fifth-order comb decimation
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      c5_dec_q <= RST_ZERO[7:0];
    end else if (wr_c5_dec) begin
      c5_dec_q <= I_PWDATA[7:0];
    end
  end

  // Fifth-order comb scale
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      c5_scl_q <= RST_ZERO[C5_SCL_W-1:0];
    end else if (wr_c5_scl) begin
      c5_scl_q <= I_PWDATA[C5_SCL_W-1:0];
    end
  end

  // Coefficient filter decimation
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cf_dec_q <= RST_ZERO[7:0];
    end else if (wr_cf_dec) begin
      cf_dec_q <= I_PWDATA[7:0];
    end
  end

  // Coefficient filter phase
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cf_phase_q <= RST_ZERO[7:0];
    end else if (wr_cf_phase) begin
      cf_phase_q <= I_PWDATA[7:0];
    end
  end

  // Coefficient filter taps
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cf_taps_q <= RST_ZERO[7:0];
    end else if (wr_cf_taps) begin
      cf_taps_q <= I_PWDATA[7:0];
    end
  end

  // Coefficient offset shadow
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cf_off_shadow_q <= RST_ZERO[7:0];
    end else if (wr_cf_off) begin
      cf_off_shadow_q <= I_PWDATA[7:0];
    end
  end

  // Coefficient filter control
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cf_ctrl_q <= RST_ZERO[CF_CTRL_W-1:0];
    end else if (wr_cf_ctrl) begin
      cf_ctrl_q <= I_PWDATA[CF_CTRL_W-1:0];
    end
  end

  // Working coefficient offset
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cf_off_work_q <= RST_ZERO[7:0];
    end else if (I_OUT_SAMPLE) begin
      cf_off_work_q <= cf_off_shadow_q;
    end
  end

  // Phase taken at each filter start; sync does not touch it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      phase_work_q <= RST_ZERO[7:0];
    end else if (I_FILT_START) begin
      phase_work_q <= cf_phase_q;
    end
  end

  // Read mux
  always_comb begin
    rdata_d = RST_ZERO;
    case (idx)
      IDX_OSC_CTRL: rdata_d[OSC_W-1:0] = osc_q;
      IDX_RS_DEC: rdata_d[RS_DEC_W-1:0] = rs_dec_q;
      IDX_RS_INTERP: rdata_d[RS_INT_W-1:0] = rs_int_q;
      IDX_RS_SCALE: rdata_d[RS_SCL_W-1:0] = rs_scl_q;
      IDX_C5_DEC: rdata_d[7:0] = c5_dec_q;
      IDX_C5_SCALE: rdata_d[C5_SCL_W-1:0] = c5_scl_q;
      IDX_CF_DEC: rdata_d[7:0] = cf_dec_q;
      IDX_CF_PHASE: rdata_d[7:0] = cf_phase_q;
      IDX_CF_TAPS: rdata_d[7:0] = cf_taps_q;
      IDX_CF_OFFSET: rdata_d[7:0] = cf_off_shadow_q;
      IDX_CF_CTRL: rdata_d[CF_CTRL_W-1:0] = cf_ctrl_q;
      IDX_SIG_I: rdata_d[SIG_W-1:0] = I_SIG_I;
      IDX_SIG_Q: rdata_d[SIG_W-1:0] = I_SIG_Q;
      default: rdata_d = RST_ZERO;
    endcase
  end

  // APB answer: ready in the access cycle, data captured in setup
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_PRDATA <= RST_ZERO;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= 1'b0;
      if (rd_en) begin
        O_PRDATA <= rdata_d;
      end
    end
  end

  // Coefficient memory write port with bank bit as address MSB
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_COEFFICIENT_MEMORY_WE <= 1'b0;
      O_COEFFICIENT_MEMORY_ADDR <= RST_ZERO[7:0];
      O_COEFFICIENT_MEMORY_WDATA <= RST_ZERO[19:0];
    end else begin
      O_COEFFICIENT_MEMORY_WE <= wr_en & (idx <= IDX_COEFFICIENT_MEMORY_LAST);
      O_COEFFICIENT_MEMORY_ADDR <= {cf_ctrl_q[CF_BANK], idx[6:0]};
      O_COEFFICIENT_MEMORY_WDATA <= I_PWDATA[19:0];
    end
  end

  // Oscillator settings
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_OSC_CFG <= '0;
    end else begin
      O_OSC_CFG.sync_sel <= osc_q[OSC_SYNC_HI:OSC_SYNC_LO];
      O_OSC_CFG.port_b <= osc_q[OSC_PORT];
      O_OSC_CFG.clr_on_hop <= osc_q[OSC_CLR_HOP];
      O_OSC_CFG.amp_dither <= osc_q[OSC_AMP_DITH];
      O_OSC_CFG.ph_dither <= osc_q[OSC_PH_DITH];
      O_OSC_CFG.bypass <= osc_q[OSC_BYPASS];
    end
  end

  // Coefficient filter control settings
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_CF_CFG <= '0;
    end else begin
      O_CF_CFG.bypass_sig <= cf_ctrl_q[CF_BYP_SIG];
      O_CF_CFG.src_other <= cf_ctrl_q[CF_SRC_OTHER];
      O_CF_CFG.bank <= cf_ctrl_q[CF_BANK];
      O_CF_CFG.common_exp <= cf_ctrl_q[CF_COMMON_EXP];
      O_CF_CFG.force_scale <= cf_ctrl_q[CF_FORCE_SCL];
      O_CF_CFG.fmt <= cf_ctrl_q[CF_FMT_HI] ? FMT_FLOAT12 :
                      (cf_ctrl_q[CF_FMT_LO] ? FMT_FLOAT8 : FMT_FIXED);
      O_CF_CFG.scale <= cf_ctrl_q[CF_SCL_HI:CF_SCL_LO];
    end
  end

  // Filter settings, pointer and other-channel source
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_FILT_CFG <= '0;
      O_FIRST_PHASE <= 1'b0;
      O_COEF_PTR <= RST_ZERO[7:0];
    end else begin
      O_FILT_CFG.rs_dec_m1 <= rs_dec_q;
      O_FILT_CFG.rs_int_m1 <= rs_int_q;
      O_FILT_CFG.rs_scale <= I_LEVEL_IND ? rs_scl_q[RS_LOUD_HI:RS_LOUD_LO] :
                             rs_scl_q[RS_QUIET_HI:RS_QUIET_LO];
      O_FILT_CFG.c5_dec_m1 <= c5_dec_q;
      O_FILT_CFG.c5_scale <= c5_scl_q;
      O_FILT_CFG.cf_dec_m1 <= cf_dec_q;
      O_FILT_CFG.cf_phase <= phase_work_q;
      O_FILT_CFG.cf_taps_m1 <= cf_taps_q;
      O_FILT_CFG.cf_offset <= cf_off_work_q;
      O_COEF_PTR <= cf_off_work_q;
      // Other-channel source: channel 1 takes 0, all others take 1
      O_FIRST_PHASE <= (CHAN_ID == 1) ? 1'b0 : 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: verilog/chan_cfg_pkg.sv
/*
  Constants and carrier types for the channel configuration register bank.
  Assumes an APB master with 32-bit data and word-aligned register addresses.
*/
package chan_cfg_pkg;
  // Printed offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_OSC_CTRL = 8'h88;
  localparam logic [7:0] IDX_RS_DEC = 8'h90;
  localparam logic [7:0] IDX_RS_INTERP = 8'h91;
  localparam logic [7:0] IDX_RS_SCALE = 8'h92;
  localparam logic [7:0] IDX_RSVD_A = 8'h93;
  localparam logic [7:0] IDX_C5_DEC = 8'h94;
  localparam logic [7:0] IDX_C5_SCALE = 8'h95;
  localparam logic [7:0] IDX_RSVD_B = 8'h96;
  localparam logic [7:0] IDX_CF_DEC = 8'hA0;
  localparam logic [7:0] IDX_CF_PHASE = 8'hA1;
  localparam logic [7:0] IDX_CF_TAPS = 8'hA2;
  localparam logic [7:0] IDX_CF_OFFSET = 8'hA3;
  localparam logic [7:0] IDX_CF_CTRL = 8'hA4;
  localparam logic [7:0] IDX_SIG_I = 8'hA5;
  localparam logic [7:0] IDX_SIG_Q = 8'hA6;
  localparam logic [7:0] IDX_COEFFICIENT_MEMORY_LAST = 8'h7F;
  localparam int ADDR_W = 10;

  // Register widths
  localparam int OSC_W = 9;
  localparam int RS_DEC_W = 12;
  localparam int RS_INT_W = 9;
  localparam int RS_SCL_W = 12;
  localparam int C5_SCL_W = 5;
  localparam int CF_CTRL_W = 11;
  localparam int SIG_W = 16;

  // Oscillator control fields
  localparam int OSC_SYNC_HI = 8;
  localparam int OSC_SYNC_LO = 7;
  localparam int OSC_PORT = 6;
  localparam int OSC_CLR_HOP = 3;
  localparam int OSC_AMP_DITH = 2;
  localparam int OSC_PH_DITH = 1;
  localparam int OSC_BYPASS = 0;
  localparam logic [OSC_W-1:0] OSC_WMASK = 9'h1_CF;

  // Resample scale fields
  localparam int RS_LOUD_HI = 9;
  localparam int RS_LOUD_LO = 5;
  localparam int RS_QUIET_HI = 4;
  localparam int RS_QUIET_LO = 0;
  localparam logic [RS_SCL_W-1:0] RS_SCL_WMASK = 12'h3_FF;

  // Coefficient filter control fields
  localparam int CF_BYP_SIG = 10;
  localparam int CF_SRC_OTHER = 9;
  localparam int CF_BANK = 8;
  localparam int CF_COMMON_EXP = 7;
  localparam int CF_FORCE_SCL = 6;
  localparam int CF_FMT_HI = 5;
  localparam int CF_FMT_LO = 4;
  localparam int CF_SCL_HI = 3;
  localparam int CF_SCL_LO = 0;

  // Output formats
  typedef enum logic [1:0] {
    FMT_FIXED = 2'b00,
    FMT_FLOAT8 = 2'b01,
    FMT_FLOAT12 = 2'b10
  } out_fmt_t;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] sync_sel;
    logic port_b;
    logic clr_on_hop;
    logic amp_dither;
    logic ph_dither;
    logic bypass;
  } osc_cfg_t;

  typedef struct packed {
    logic bypass_sig;
    logic src_other;
    logic bank;
    logic common_exp;
    logic force_scale;
    out_fmt_t fmt;
    logic [3:0] scale;
  } cf_cfg_t;

  typedef struct packed {
    logic [11:0] rs_dec_m1;
    logic [8:0] rs_int_m1;
    logic [4:0] rs_scale;
    logic [7:0] c5_dec_m1;
    logic [4:0] c5_scale;
    logic [7:0] cf_dec_m1;
    logic [7:0] cf_phase;
    logic [7:0] cf_taps_m1;
    logic [7:0] cf_offset;
  } filt_cfg_t;
endpackage

// File: verif/chan_cfg_regs_asserts.sv
/* Port checker for the channel configuration register bank.
   Bound to chan_cfg_regs; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module chan_cfg_regs_asserts
  import chan_cfg_pkg::*;
(
  // Watched ports
  input wire logic I_SYS_CLK, I_RST_B, I_PSEL, I_PENABLE, I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA, O_PRDATA,
  input wire logic O_PREADY, O_PSLVERR, I_LEVEL_IND, I_OUT_SAMPLE, O_COEFFICIENT_MEMORY_WE,
  input wire osc_cfg_t O_OSC_CFG,
  input wire cf_cfg_t O_CF_CFG,
  input wire filt_cfg_t O_FILT_CFG,
  input wire logic [7:0] O_COEF_PTR, O_COEFFICIENT_MEMORY_ADDR
);
  logic [31:0] wd_q, wd_qq;
  logic [7:0] idx_q, shadow_q;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  always_ff @(posedge I_SYS_CLK) begin
    wd_q <= I_PWDATA;
    wd_qq <= wd_q;
    idx_q <= I_PADDR[9:2];
  end
  // Model of the offset shadow
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) shadow_q <= 8'h00;
    else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR[9:2] == IDX_CF_OFFSET)
      shadow_q <= I_PWDATA[7:0];
  end
  sequence s_setup; I_PSEL && !I_PENABLE; endsequence
  sequence s_wr(logic [7:0] idx); I_PSEL && I_PENABLE && I_PWRITE && I_PADDR[9:2] == idx;
  endsequence
  property p_ready; s_setup |=> O_PREADY ##1 !O_PREADY; endproperty
  property p_noerr; O_PREADY |-> !O_PSLVERR; endproperty
  property p_osc; s_wr(IDX_OSC_CTRL) |-> ##2 O_OSC_CFG == {wd_qq[8:6], wd_qq[3:0]}; endproperty
  property p_cf; s_wr(IDX_CF_CTRL) |-> ##2 O_CF_CFG[10:6] == wd_qq[10:6] &&
    O_CF_CFG.scale == wd_qq[3:0] && O_CF_CFG.fmt[1] == wd_qq[5] &&
    O_CF_CFG.fmt[0] == (!wd_qq[5] && wd_qq[4]); endproperty
  property p_rscale; s_wr(IDX_RS_SCALE) |-> ##2
    O_FILT_CFG.rs_scale == ($past(I_LEVEL_IND) ? wd_qq[9:5] : wd_qq[4:0]); endproperty
  property p_ptr; I_OUT_SAMPLE |-> ##2 O_COEF_PTR == $past(shadow_q, 2); endproperty
  property p_coefficient_memory; I_PSEL && I_PENABLE && I_PWRITE && !I_PADDR[9] |=>
    O_COEFFICIENT_MEMORY_WE && O_COEFFICIENT_MEMORY_ADDR == {O_CF_CFG.bank, idx_q[6:0]}; endproperty
  property p_unused; s_setup and (!I_PWRITE &&
    (I_PADDR[9:2] inside {[8'h89:8'h8F], 8'h93, [8'h96:8'h9F]})) |=> O_PRDATA == 32'h0000_0000;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not one cycle after setup");
  a_noerr: assert property (p_noerr)
    else $error("error response seen");
  a_osc: assert property (p_osc)
    else $error("oscillator config mismatch");
  a_cf: assert property (p_cf)
    else $error("filter control mismatch");
  a_rscale: assert property (p_rscale)
    else $error("resample scale field wrong");
  a_ptr: assert property (p_ptr)
    else $error("coefficient pointer not loaded");
  a_coefficient_memory: assert property (p_coefficient_memory)
    else $error("coefficient write address wrong");
  a_unused: assert property (p_unused)
    else $error("unused address not zero");
endmodule
bind chan_cfg_regs chan_cfg_regs_asserts u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_LEVEL_IND(I_LEVEL_IND),
  .I_OUT_SAMPLE(I_OUT_SAMPLE), .O_COEFFICIENT_MEMORY_WE(O_COEFFICIENT_MEMORY_WE), .O_OSC_CFG(O_OSC_CFG),
  .O_CF_CFG(O_CF_CFG), .O_FILT_CFG(O_FILT_CFG), .O_COEF_PTR(O_COEF_PTR),
  .O_COEFFICIENT_MEMORY_ADDR(O_COEFFICIENT_MEMORY_ADDR));
`default_nettype wire

// File: verif/tb.sv
/* Self-checking bench for the channel configuration register bank.
   Drives APB and channel status pins itself; checker bound separately. */
`timescale 1ns/1ns
`default_nettype none
module tb
  import chan_cfg_pkg::*;
;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic lvl = 0, fstart = 0, osamp = 0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, fphase, cwe;
  logic [15:0] sig_i = 16'h1234, sig_q = 16'hBEEF;
  osc_cfg_t osc;
  cf_cfg_t cf;
  filt_cfg_t filt;
  logic [7:0] cptr, caddr;
  logic [19:0] cwdata;
  int bad_count = 0, check_count = 0;
  logic [7:0] tidx [16] = '{8'h88, 8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'hA0, 8'hA1,
    8'hA2, 8'hA3, 8'hA4, 8'h89, 8'h8F, 8'h93, 8'h96, 8'h9F};
  logic [11:0] texp [16] = '{12'h1CF, 12'hFFF, 12'h1FF, 12'h3FF, 12'h0FF, 12'h01F,
    12'h0FF, 12'h0FF, 12'h0FF, 12'h0FF, 12'h7DF, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0};
  chan_cfg_regs #(.CHAN_ID(0)) DUT (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LEVEL_IND(lvl),
    .I_FILT_START(fstart), .I_OUT_SAMPLE(osamp), .I_SIG_I(sig_i), .I_SIG_Q(sig_q),
    .O_OSC_CFG(osc), .O_CF_CFG(cf), .O_FILT_CFG(filt), .O_FIRST_PHASE(fphase),
    .O_COEF_PTR(cptr), .O_COEFFICIENT_MEMORY_WE(cwe), .O_COEFFICIENT_MEMORY_ADDR(caddr), .O_COEFFICIENT_MEMORY_WDATA(cwdata));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize;
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // Pulse output-sample (1) or filter-start (0) for one cycle
  task automatic pulse(input logic smp);
    if (smp) osamp <= 1;
    else fstart <= 1;
    @(posedge clk);
    osamp <= 0;
    fstart <= 0;
    tick(2);
  endtask
  initial begin
    tick(5000);
    bad_count++;
    summarize();
  end
  initial begin
    tick(20);
    rst_b <= 1;
    tick(2);
    check("first_phase", fphase, 1'b1);
    for (int i = 0; i < 16; i++) begin
      apb(0, tidx[i], 32'h0);
      check("reset_value", rd, 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      apb(1, tidx[i], tidx[i] == IDX_CF_CTRL ? 32'hFFFF_F7DF : 32'hFFFF_FFFF);
      apb(0, tidx[i], 32'h0);
      check("readback", rd, {20'h0, texp[i]});
    end
    check("osc", osc, 7'h7F);
    check("cf", cf, 11'h7DF);
    check("ptr_held", cptr, 8'h00);
    check("phase_held", filt.cf_phase, 8'h00);
    pulse(1);
    pulse(0);
    check("ptr", cptr, 8'hFF);
    check("filt", filt, {12'hFFF, 9'h1FF, 5'h1F, 8'hFF, 5'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    apb(1, 8'h05, 32'h000A_BCDE);
    check("coefficient_memory", {cwe, caddr, cwdata}, {1'b1, 8'h85, 20'hABCDE});
    for (int s = 0; s < 4; s++) begin
      apb(1, IDX_OSC_CTRL, {23'h0, s[1:0], 7'h41});
      tick(1);
      check("sync", osc, {s[1:0], 5'b10001});
    end
    apb(1, IDX_RS_SCALE, 32'h0000_02A3);
    tick(1);
    check("quiet_scale", filt.rs_scale, 5'h03);
    lvl <= 1;
    tick(2);
    check("loud_scale", filt.rs_scale, 5'h15);
    apb(0, IDX_SIG_I, 32'h0);
    check("sig_i", rd, 32'h0000_1234);
    apb(0, IDX_SIG_Q, 32'h0);
    check("sig_q", rd, 32'h0000_BEEF);
    apb(1, IDX_CF_CTRL, 32'h0000_0030);
    tick(1);
    check("fmt_wide", cf, 11'h020);
    apb(1, IDX_CF_CTRL, 32'h0000_0000);
    tick(1);
    check("fmt_fixed", cf, 11'h000);
    summarize();
  end
endmodule
`default_nettype wire
